// ---- hw/pkt_buffer.sv ----
// packet buffer between transaction-layer and link-layer streams
// assumes both stream partners and the bus master run on clock_i
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pkt_buffer (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic buf_arst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic tl_tx_tvalid_i,
  output logic tl_tx_tready_o,
  input wire logic [63:0] tl_tx_tdata_i,
  input wire logic [7:0] tl_tx_tkeep_i,
  input wire logic tl_tx_tlast_i,
  input wire logic [7:0] tl_tx_tuser_i,
  output logic tl_rx_tvalid_o,
  input wire logic tl_rx_tready_i,
  output logic [63:0] tl_rx_tdata_o,
  output logic [7:0] tl_rx_tkeep_o,
  output logic tl_rx_tlast_o,
  output logic [7:0] tl_rx_tuser_o,
  output logic ll_tx_tvalid_o,
  input wire logic ll_tx_tready_i,
  output logic [63:0] ll_tx_tdata_o,
  output logic [7:0] ll_tx_tkeep_o,
  output logic ll_tx_tlast_o,
  output logic [7:0] ll_tx_tuser_o,
  input wire logic ll_rx_tvalid_i,
  output logic ll_rx_tready_o,
  input wire logic [63:0] ll_rx_tdata_i,
  input wire logic [7:0] ll_rx_tkeep_i,
  input wire logic ll_rx_tlast_i,
  input wire logic [7:0] ll_rx_tuser_i,
  output logic response_only_o,
  input wire logic request_enable_i,
  input wire logic long_symbol_mode_i,
  input wire logic rewind_i,
  input wire logic [5:0] next_packet_id_i,
  input wire logic [5:0] last_ack_id_i,
  output logic [5:0] rx_buf_status_o,
  output logic tx_flow_control_o
);
  localparam int SLOTS = pbuf_pkg::SLOTS;

  logic req_en_s, long_s, fc_mode;
  logic [1:0] tx_dsel, rx_dsel;
  logic [5:0] tx_depth, rx_depth, id_mask;
  logic [31:0] status_word;
  // transmit storage and slot table
  logic [71:0] tx_mem [SLOTS*pbuf_pkg::TX_BEATS];
  logic [SLOTS-1:0] slot_valid_ff, slot_sent_ff, slot_resp_ff, slot_crf_ff, ack_hit;
  logic [5:0] slot_len_ff [SLOTS];
  logic [5:0] slot_id_ff [SLOTS];
  logic wr_active_ff, wr_resp_ff, wr_crf_ff, tl_take, any_free;
  logic [4:0] wr_slot_ff, cur_slot, free_idx;
  logic [5:0] wr_beat_ff, cur_beat, free_cnt, free_after;
  logic cur_resp, cur_crf, wr_done, nxt_active;
  // transmit scheduling
  pbuf_pkg::tx_state_t state_ff;
  logic pick_ok, rep_ok, replay_ff, abort_ff, send_new_ff;
  logic [4:0] pick_slot, rep_slot, send_slot_ff;
  logic [5:0] send_beat_ff, send_id_ff, seq_ff, replay_id_ff, prev_ack_ff, ack_span;
  logic ll_adv, send_last, send_disc, mark_sent, ack_move;
  logic [71:0] tx_ent;
  // receive side
  logic [pbuf_pkg::RX_W-1:0] rx_mem [pbuf_pkg::RX_ENTRIES];
  logic [pbuf_pkg::RX_W-1:0] rx_ent;
  logic [7:0] wptr_ff, cptr_ff, start_ff, rptr_ff, nxt_wptr, nxt_rptr, rx_used;
  logic rx_take, rx_first_ff, rx_commit, rx_pop, rx_pop_last, rd_adv, rx_sop_ff;
  logic [5:0] rx_pkts_ff, rx_free;

  pbuf_sync2 u_req_sync (
    .clock_i(clock_i),
    .arst_i(buf_arst_i),
    .d_i(request_enable_i),
    .q_o(req_en_s)
  );
  pbuf_sync2 u_long_sync (
    .clock_i(clock_i),
    .arst_i(buf_arst_i),
    .d_i(long_symbol_mode_i),
    .q_o(long_s)
  );
  pbuf_cfg u_cfg (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .address_i(avs_address_i),
    .read_i(avs_read_i),
    .write_i(avs_write_i),
    .writedata_i(avs_writedata_i),
    .byteenable_i(avs_byteenable_i),
    .readdata_o(avs_readdata_o),
    .waitrequest_o(avs_waitrequest_o),
    .status_i(status_word),
    .fc_mode_o(fc_mode),
    .tx_depth_sel_o(tx_dsel),
    .rx_depth_sel_o(rx_dsel)
  );

  assign tx_depth = pbuf_pkg::depth_slots(tx_dsel);
  assign rx_depth = pbuf_pkg::depth_slots(rx_dsel);
  assign id_mask = long_s ? pbuf_pkg::ID_MASK_LONG : pbuf_pkg::ID_MASK_SHORT;
  assign status_word = {14'h0000, replay_ff, response_only_o, 2'h0, rx_pkts_ff, 2'h0, free_cnt};

  // ---- transmit fill from the transaction layer
  assign tl_take = tl_tx_tvalid_i && tl_tx_tready_o;
  assign cur_slot = wr_active_ff ? wr_slot_ff : free_idx;
  assign cur_beat = wr_active_ff ? wr_beat_ff : 6'h00;
  assign cur_resp = wr_active_ff ? wr_resp_ff : tl_tx_tuser_i[pbuf_pkg::U_RESP];
  assign cur_crf = wr_active_ff ? wr_crf_ff : tl_tx_tuser_i[pbuf_pkg::U_CRF];
  assign wr_done = tl_take && tl_tx_tlast_i;
  assign nxt_active = tl_take ? !tl_tx_tlast_i : wr_active_ff;
  assign free_after = (tl_take && !wr_active_ff) ? free_cnt - 6'h01 : free_cnt;

  always_comb begin
    free_idx = 5'h00;
    free_cnt = 6'h00;
    any_free = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (6'(i) < tx_depth && !slot_valid_ff[i] && !(wr_active_ff && wr_slot_ff == 5'(i))) begin
        if (!any_free) free_idx = 5'(i);
        any_free = 1'b1;
        free_cnt = free_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (tl_take && cur_beat < 6'(pbuf_pkg::TX_BEATS)) begin
      tx_mem[pbuf_pkg::tx_idx(cur_slot, cur_beat)] <= {tl_tx_tkeep_i, tl_tx_tdata_i};
    end
  end

  always_ff @(posedge clock_i or posedge buf_arst_i) begin
    if (buf_arst_i) begin
      wr_active_ff <= 1'b0;
      wr_slot_ff <= 5'h00;
      wr_beat_ff <= 6'h00;
      wr_resp_ff <= 1'b0;
      wr_crf_ff <= 1'b0;
      tl_tx_tready_o <= 1'b0;
      response_only_o <= 1'b0;
    end else begin
      if (tl_take) begin
        wr_active_ff <= !tl_tx_tlast_i;
        wr_slot_ff <= cur_slot;
        wr_beat_ff <= cur_beat + 6'h01;
        wr_resp_ff <= cur_resp;
        wr_crf_ff <= cur_crf;
      end
      tl_tx_tready_o <= nxt_active || free_after != 6'h00;
      response_only_o <= free_after <= pbuf_pkg::RESP_RESERVE;
    end
  end

  // ---- acknowledge window: ids in (prev, last] are released
  assign ack_move = ((last_ack_id_i ^ prev_ack_ff) & id_mask) != 6'h00;
  assign ack_span = (last_ack_id_i - prev_ack_ff) & id_mask;
  generate
    for (genvar g = 0; g < SLOTS; g++) begin : g_ack
      assign ack_hit[g] = ack_move && slot_sent_ff[g]
        && (((slot_id_ff[g] - prev_ack_ff - 6'h01) & id_mask) < ack_span);
    end
  endgenerate

  always_ff @(posedge clock_i or posedge buf_arst_i) begin
    if (buf_arst_i) begin
      slot_valid_ff <= '0;
      slot_sent_ff <= '0;
      slot_resp_ff <= '0;
      slot_crf_ff <= '0;
      prev_ack_ff <= pbuf_pkg::ID_RESET;
      for (int i = 0; i < SLOTS; i++) begin
        slot_len_ff[i] <= 6'h00;
        slot_id_ff[i] <= 6'h00;
      end
    end else begin
      prev_ack_ff <= last_ack_id_i & id_mask;
      slot_valid_ff <= slot_valid_ff & ~ack_hit;
      slot_sent_ff <= slot_sent_ff & ~ack_hit;
      if (wr_done) begin
        slot_valid_ff[cur_slot] <= 1'b1;
        slot_sent_ff[cur_slot] <= 1'b0;
        slot_resp_ff[cur_slot] <= cur_resp;
        slot_crf_ff[cur_slot] <= cur_crf;
        slot_len_ff[cur_slot] <= cur_beat + 6'h01;
      end
      if (mark_sent) begin
        slot_sent_ff[send_slot_ff] <= 1'b1;
        slot_id_ff[send_slot_ff] <= send_id_ff;
      end
    end
  end

  // ---- transmit scheduling toward the link
  always_comb begin
    pick_ok = 1'b0;
    pick_slot = 5'h00;
    rep_ok = 1'b0;
    rep_slot = 5'h00;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (slot_valid_ff[i] && !slot_sent_ff[i] && !slot_resp_ff[i] && req_en_s) begin
        pick_ok = 1'b1;
        pick_slot = 5'(i);
      end
    end
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (slot_valid_ff[i] && !slot_sent_ff[i] && slot_resp_ff[i]) begin
        pick_ok = 1'b1;
        pick_slot = 5'(i);
      end
      if (slot_valid_ff[i] && slot_sent_ff[i] && slot_id_ff[i] == replay_id_ff) begin
        rep_ok = 1'b1;
        rep_slot = 5'(i);
      end
    end
  end

  assign ll_adv = !ll_tx_tvalid_o || ll_tx_tready_i;
  assign tx_ent = tx_mem[pbuf_pkg::tx_idx(send_slot_ff, send_beat_ff)];
  assign send_last = send_beat_ff == slot_len_ff[send_slot_ff] - 6'h01;
  assign send_disc = abort_ff || rewind_i;
  assign mark_sent = state_ff == pbuf_pkg::TX_SEND && ll_adv && send_last && !send_disc;

  always_ff @(posedge clock_i or posedge buf_arst_i) begin
    if (buf_arst_i) begin
      state_ff <= pbuf_pkg::TX_IDLE;
      replay_ff <= 1'b0;
      replay_id_ff <= 6'h00;
      seq_ff <= 6'h00;
      abort_ff <= 1'b0;
      send_new_ff <= 1'b0;
      send_slot_ff <= 5'h00;
      send_beat_ff <= 6'h00;
      send_id_ff <= 6'h00;
      ll_tx_tvalid_o <= 1'b0;
      ll_tx_tdata_o <= 64'h0000_0000_0000_0000;
      ll_tx_tkeep_o <= 8'h00;
      ll_tx_tlast_o <= 1'b0;
      ll_tx_tuser_o <= 8'h00;
    end else begin
      if (rewind_i) begin
        replay_ff <= 1'b1;
        replay_id_ff <= next_packet_id_i & id_mask;
      end else if (state_ff == pbuf_pkg::TX_IDLE && replay_ff && !rep_ok) begin
        replay_ff <= 1'b0;
      end else if (mark_sent && !send_new_ff) begin
        replay_id_ff <= (replay_id_ff + 6'h01) & id_mask;
      end
      if (mark_sent && send_new_ff) seq_ff <= (seq_ff + 6'h01) & id_mask;
      if (ll_adv) begin
        ll_tx_tvalid_o <= state_ff == pbuf_pkg::TX_SEND;
        ll_tx_tdata_o <= tx_ent[63:0];
        ll_tx_tkeep_o <= tx_ent[71:64];
        ll_tx_tlast_o <= send_last;
        ll_tx_tuser_o <= {6'h00, send_beat_ff == 6'h00 && slot_crf_ff[send_slot_ff],
          send_last && send_disc};
      end
      unique case (state_ff)
        pbuf_pkg::TX_IDLE: begin
          send_beat_ff <= 6'h00;
          abort_ff <= 1'b0;
          if (!rewind_i && replay_ff && rep_ok) begin
            state_ff <= pbuf_pkg::TX_SEND;
            send_slot_ff <= rep_slot;
            send_new_ff <= 1'b0;
            send_id_ff <= replay_id_ff;
          end else if (!rewind_i && !replay_ff && pick_ok) begin
            state_ff <= pbuf_pkg::TX_SEND;
            send_slot_ff <= pick_slot;
            send_new_ff <= 1'b1;
            send_id_ff <= seq_ff;
          end
        end
        pbuf_pkg::TX_SEND: begin
          if (ll_adv) begin
            send_beat_ff <= send_beat_ff + 6'h01;
            if (send_last) state_ff <= pbuf_pkg::TX_IDLE;
          end
          if (rewind_i && !(ll_adv && send_last)) abort_ff <= 1'b1;
        end
        default: state_ff <= pbuf_pkg::TX_IDLE;
      endcase
    end
  end

  // ---- receive from the link
  assign rx_take = ll_rx_tvalid_i && ll_rx_tready_o;
  assign rx_commit = rx_take && ll_rx_tlast_i && !ll_rx_tuser_i[pbuf_pkg::U_DISC];
  assign rd_adv = !tl_rx_tvalid_o || tl_rx_tready_i;
  assign rx_pop = rd_adv && rptr_ff != cptr_ff;
  assign rx_ent = rx_mem[rptr_ff];
  assign rx_pop_last = rx_pop && rx_ent[72];
  assign nxt_rptr = rx_pop ? rptr_ff + 8'h01 : rptr_ff;
  assign rx_used = nxt_wptr - nxt_rptr;
  assign rx_free = rx_depth - rx_pkts_ff;

  always_comb begin
    nxt_wptr = wptr_ff;
    if (rx_take) begin
      if (ll_rx_tlast_i && ll_rx_tuser_i[pbuf_pkg::U_DISC]) nxt_wptr = start_ff;
      else nxt_wptr = wptr_ff + 8'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rx_take) begin
      rx_mem[wptr_ff] <= {rx_first_ff && ll_rx_tuser_i[pbuf_pkg::U_CRF], ll_rx_tlast_i,
        ll_rx_tkeep_i, ll_rx_tdata_i};
    end
  end

  always_ff @(posedge clock_i or posedge buf_arst_i) begin
    if (buf_arst_i) begin
      wptr_ff <= 8'h00;
      start_ff <= 8'h00;
      cptr_ff <= 8'h00;
      rx_first_ff <= 1'b1;
      rx_pkts_ff <= 6'h00;
      ll_rx_tready_o <= 1'b0;
      rx_buf_status_o <= 6'h00;
    end else begin
      wptr_ff <= nxt_wptr;
      if (rx_take) rx_first_ff <= ll_rx_tlast_i;
      if (rx_commit) begin
        start_ff <= nxt_wptr;
        cptr_ff <= nxt_wptr;
      end
      rx_pkts_ff <= rx_pkts_ff + 6'(rx_commit) - 6'(rx_pop_last);
      ll_rx_tready_o <= rx_used < pbuf_pkg::RX_FULL_MARK && rx_pkts_ff + 6'(rx_commit) < rx_depth;
      rx_buf_status_o <= (rx_free > pbuf_pkg::STAT_CAP) ?
        pbuf_pkg::STAT_CAP : rx_free;
    end
  end

  always_ff @(posedge clock_i or posedge buf_arst_i) begin
    if (buf_arst_i) begin
      rptr_ff <= 8'h00;
      rx_sop_ff <= 1'b1;
      tl_rx_tvalid_o <= 1'b0;
      tl_rx_tdata_o <= 64'h0000_0000_0000_0000;
      tl_rx_tkeep_o <= 8'h00;
      tl_rx_tlast_o <= 1'b0;
      tl_rx_tuser_o <= 8'h00;
    end else begin
      rptr_ff <= nxt_rptr;
      if (rd_adv) begin
        tl_rx_tvalid_o <= rx_pop;
        tl_rx_tdata_o <= rx_ent[63:0];
        tl_rx_tkeep_o <= rx_ent[71:64];
        tl_rx_tlast_o <= rx_ent[72];
        tl_rx_tuser_o <= {4'h0, rx_sop_ff, 1'b0, rx_ent[73], 1'b0};
      end
      if (rx_pop) rx_sop_ff <= rx_ent[72];
    end
  end

  // flow-control mode is a register bit
  always_ff @(posedge clock_i or posedge buf_arst_i) begin
    if (buf_arst_i) tx_flow_control_o <= 1'b0;
    else tx_flow_control_o <= fc_mode;
  end

  keep_full_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    ll_tx_tvalid_o && !ll_tx_tlast_o && $past(ll_adv) && $past(state_ff) == pbuf_pkg::TX_SEND
      |-> ll_tx_tkeep_o == $past(tx_ent[71:64]))
    else $error("link keep not taken from stored beat");
  keep_all_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    ll_tx_tvalid_o && !ll_tx_tlast_o |-> ll_tx_tkeep_o == pbuf_pkg::KEEP_ALL)
    else $error("link keep not all ones before last beat");
  sop_mark_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    tl_rx_tvalid_o && tl_rx_tready_i && tl_rx_tlast_o
      ##1 tl_rx_tvalid_o |-> tl_rx_tuser_o[pbuf_pkg::U_SOP])
    else $error("start mark missing after packet end");
  stat_safe_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    rx_buf_status_o <= pbuf_pkg::STAT_CAP && rx_buf_status_o[4:0] != 5'h1F)
    else $error("receive status may read as flow control");
  req_gate_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    state_ff == pbuf_pkg::TX_IDLE ##1 state_ff == pbuf_pkg::TX_SEND && send_new_ff
      |-> slot_resp_ff[send_slot_ff] || $past(req_en_s))
    else $error("request started while requests disabled");
  drop_pkt_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    rx_take && ll_rx_tlast_i && ll_rx_tuser_i[pbuf_pkg::U_DISC]
      |=> wptr_ff == $past(start_ff) && $stable(cptr_ff))
    else $error("abandoned packet not dropped");
  ack_only_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    $fell(slot_valid_ff[0]) |-> $past(ack_move) && $past(slot_sent_ff[0]))
    else $error("slot freed without acknowledge");
  rewind_follow_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    rewind_i |=> replay_ff && replay_id_ff == ($past(next_packet_id_i) & $past(id_mask)))
    else $error("rewind did not follow next identifier");
  resp_only_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    !tl_take && !ack_move && !wr_active_ff ##1 !tl_take
      |-> response_only_o == (free_cnt <= pbuf_pkg::RESP_RESERVE))
    else $error("response-only level disagrees with free slots");
  fc_track_a: assert property (@(posedge clock_i) disable iff (buf_arst_i)
    $rose(fc_mode) |=> tx_flow_control_o)
    else $error("flow-control output lags mode bit");
  sent_c: cover property (@(posedge clock_i) mark_sent);
  rewind_c: cover property (@(posedge clock_i) rewind_i && state_ff == pbuf_pkg::TX_SEND);
  drop_c: cover property (@(posedge clock_i) rx_take && ll_rx_tlast_i && ll_rx_tuser_i[0]);
  multi_ack_c: cover property (@(posedge clock_i) ack_move && ack_span > 6'h01);
endmodule
`default_nettype wire

// ---- hw/pbuf_pkg.sv ----
// constants, types and helpers shared by the packet buffer files
// assumes one clock for both stream sides and the register bus
package pbuf_pkg;
  localparam int U_DISC = 0;
  localparam int U_CRF = 1;
  localparam int U_SOP = 3;
  localparam int U_RESP = 4;
  localparam logic [7:0] KEEP_ALL = 8'hFF;
  localparam int SLOTS = 32;
  localparam int TX_BEATS = 35;
  localparam int RX_ENTRIES = 256;
  localparam int RX_W = 74;
  localparam logic [5:0] ID_MASK_LONG = 6'h3F;
  localparam logic [5:0] ID_MASK_SHORT = 6'h1F;
  localparam logic [5:0] ID_RESET = 6'h3F;
  localparam logic [5:0] STAT_CAP = 6'h1E;
  localparam logic [5:0] RESP_RESERVE = 6'h02;
  localparam logic [7:0] RX_FULL_MARK = 8'hFE;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int CTRL_FC = 0;
  localparam int CTRL_TXD = 1;
  localparam int CTRL_RXD = 3;
  localparam logic [4:0] CTRL_RESET = 5'h14;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_SEND = 2'h1} tx_state_t;

  function automatic logic [5:0] depth_slots(input logic [1:0] sel);
    case (sel)
      2'h0: depth_slots = 6'h08;
      2'h1: depth_slots = 6'h10;
      default: depth_slots = 6'h20;
    endcase
  endfunction

  function automatic logic [10:0] tx_idx(input logic [4:0] slot, input logic [5:0] beat);
    tx_idx = 11'(slot) * 11'(TX_BEATS) + 11'(beat);
  endfunction
endpackage

// ---- hw/pbuf_sync2.sv ----
// two-stage level synchroniser
// assumes the input may change at any time relative to clock_i
`timescale 1ns/1ps
`default_nettype none
module pbuf_sync2 (
  input wire logic clock_i,
  input wire logic arst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;
  always_ff @(posedge clock_i or posedge arst_i) begin
    if (arst_i) begin
      meta_ff <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ---- hw/pbuf_cfg.sv ----
// avalon-mm register slave: control word and status word
// assumes a master that holds its request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module pbuf_cfg (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic [31:0] status_i,
  output logic fc_mode_o,
  output logic [1:0] tx_depth_sel_o,
  output logic [1:0] rx_depth_sel_o
);
  logic [4:0] ctrl_ff;
  logic wr_now;
  assign wr_now = write_i && !waitrequest_o && address_i == pbuf_pkg::ADDR_CTRL && byteenable_i[0];
  assign fc_mode_o = ctrl_ff[pbuf_pkg::CTRL_FC];
  assign tx_depth_sel_o = ctrl_ff[pbuf_pkg::CTRL_TXD +: 2];
  assign rx_depth_sel_o = ctrl_ff[pbuf_pkg::CTRL_RXD +: 2];

  // one wait cycle, then a single answer cycle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      waitrequest_o <= 1'b1;
      readdata_o <= 32'h0000_0000;
    end else begin
      waitrequest_o <= !((read_i || write_i) && waitrequest_o);
      if (read_i && waitrequest_o) begin
        unique case (address_i)
          pbuf_pkg::ADDR_CTRL: readdata_o <= {27'h0000000, ctrl_ff};
          pbuf_pkg::ADDR_STATUS: readdata_o <= status_i;
          default: readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_ff <= pbuf_pkg::CTRL_RESET;
    end else if (wr_now) begin
      ctrl_ff <= writedata_i[4:0];
    end
  end

  avl_answer_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus request not answered in one wait cycle");
  cfg_reset_a: assert property (@(posedge clock_i) srst_i |=> ctrl_ff == pbuf_pkg::CTRL_RESET)
    else $error("control word not at default after reset");
endmodule
`default_nettype wire

// ---- verification/link_model.sv ----
// link-side model: stalls the transmit stream, reports packet ids
// assumes one clock shared with the buffer
`timescale 1ns/1ps
`default_nettype none
module link_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tvalid_i,
  input wire logic tlast_i,
  output logic tready_o,
  output logic [5:0] next_id_o,
  output logic [5:0] ack_id_o
);
  integer seed = 76;
  logic [5:0] sent_ff;
  logic [5:0] ack_ff;
  always @(posedge clock_i) begin
    tready_o <= !rst_i && ($random(seed) % 4 != 0);
    if (rst_i) begin
      sent_ff <= 6'h00;
      ack_ff <= 6'h3F;
    end else begin
      if (tvalid_i && tready_o && tlast_i) sent_ff <= sent_ff + 6'h01;
      if (($random(seed) & 7) == 0) ack_ff <= sent_ff - 6'h01;
    end
  end
  assign next_id_o = sent_ff;
  // acknowledges lag at random, so one step may release several packets
  assign ack_id_o = ack_ff;
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// bench: drives both streams and the register bus, checks against queues
// assumes link_model.sv beside the buffer
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [63:0] d; logic [7:0] k; logic l; logic [7:0] u; logic [7:0] m;} beat_t;
  beat_t exp_ll[$];
  beat_t exp_tl[$];
  integer seed = 76, bad_count = 0, tests_run = 0, i;
  logic clock_i = 0;
  logic srst = 1, arst = 1, av_r = 0, av_w = 0, tx_v = 0, tx_l = 0, rx_r = 0, lr_v = 0, lr_l = 0;
  logic [3:0] av_a = 4'h0;
  logic [31:0] av_d = 32'h0, av_q, rdv;
  logic [63:0] tx_d = 64'h0, lr_d = 64'h0, rx_d, lt_d;
  logic [7:0] tx_k = 8'hFF, tx_u = 8'h00, lr_k = 8'hFF, lr_u = 8'h00, rx_k, rx_u, lt_k, lt_u;
  logic av_wait, tx_r, rx_v, rx_l, lt_v, lt_l, lt_r, lr_r, ronly, fc;
  logic [5:0] stat, nid, aid;
  logic ren = 1;
  initial forever #2.5 clock_i = ~clock_i;
  pkt_buffer dut (.clock_i(clock_i), .srst_i(srst), .buf_arst_i(arst), .avs_address_i(av_a),
    .avs_read_i(av_r), .avs_write_i(av_w), .avs_writedata_i(av_d), .avs_byteenable_i(4'hF),
    .avs_readdata_o(av_q), .avs_waitrequest_o(av_wait), .tl_tx_tvalid_i(tx_v),
    .tl_tx_tready_o(tx_r), .tl_tx_tdata_i(tx_d), .tl_tx_tkeep_i(tx_k), .tl_tx_tlast_i(tx_l),
    .tl_tx_tuser_i(tx_u), .tl_rx_tvalid_o(rx_v), .tl_rx_tready_i(rx_r), .tl_rx_tdata_o(rx_d),
    .tl_rx_tkeep_o(rx_k), .tl_rx_tlast_o(rx_l), .tl_rx_tuser_o(rx_u), .ll_tx_tvalid_o(lt_v),
    .ll_tx_tready_i(lt_r), .ll_tx_tdata_o(lt_d), .ll_tx_tkeep_o(lt_k), .ll_tx_tlast_o(lt_l),
    .ll_tx_tuser_o(lt_u), .ll_rx_tvalid_i(lr_v), .ll_rx_tready_o(lr_r), .ll_rx_tdata_i(lr_d),
    .ll_rx_tkeep_i(lr_k), .ll_rx_tlast_i(lr_l), .ll_rx_tuser_i(lr_u), .response_only_o(ronly),
    .request_enable_i(ren), .long_symbol_mode_i(1'b1), .rewind_i(1'b0),
    .next_packet_id_i(nid), .last_ack_id_i(aid), .rx_buf_status_o(stat),
    .tx_flow_control_o(fc));
  link_model link (.clock_i(clock_i), .rst_i(arst), .tvalid_i(lt_v), .tlast_i(lt_l),
    .tready_o(lt_r), .next_id_o(nid), .ack_id_o(aid));
  task automatic chk(input string n, input beat_t e, input beat_t g);
    tests_run++;
    if ({g.d, g.k, g.l, g.u & e.m} !== {e.d, e.k, e.l, e.u}) begin
      bad_count++;
      $display("Error %s exp %h seen %h", n, {e.d, e.k, e.l, e.u}, {g.d, g.k, g.l, g.u & e.m});
    end
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s exp %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i);
    {av_w, av_r, av_a, av_d} <= {w, !w, a, v};
    do @(posedge clock_i); while (av_wait !== 1'b0);
    rdv = av_q;
    {av_w, av_r} <= 2'h0;
  endtask
  // one packet into either side; ll selects the link receive side
  task automatic pkt(input bit ll, input int n, input bit flag, input bit critical_priority_flag);
    beat_t b;
    bit f;
    @(posedge clock_i);
    for (int j = 0; j < n; j++) begin
      f = j == 0;
      b.d = {$random(seed), $random(seed)};
      b.l = j == n - 1;
      b.k = b.l ? 8'hFF << ($random(seed) & 7) : 8'hFF;
      b.u = {3'h0, f & flag & !ll, 2'h0, f & critical_priority_flag, b.l & flag & ll};
      if (ll) {lr_v, lr_d, lr_k, lr_l, lr_u} <= {1'b1, b.d, b.k, b.l, b.u};
      else {tx_v, tx_d, tx_k, tx_l, tx_u} <= {1'b1, b.d, b.k, b.l, b.u};
      b.m = ll ? {4'h0, f, 1'b0, f, 1'b0} : {6'h0, f, b.l};
      b.u = {4'h0, f & ll, 1'b0, f & critical_priority_flag, 1'b0};
      if (!ll) exp_ll.push_back(b);
      else if (!flag) exp_tl.push_back(b);
      do @(posedge clock_i); while ((ll ? lr_r : tx_r) !== 1'b1);
    end
    if (ll) lr_v <= 1'b0;
    else tx_v <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock_i) begin
    if (lt_v === 1'b1 && lt_r === 1'b1)
      chk("link beat", exp_ll.pop_front(), '{lt_d, lt_k, lt_l, lt_u, 8'h00});
    if (rx_v === 1'b1 && rx_r === 1'b1)
      chk("tl beat", exp_tl.pop_front(), '{rx_d, rx_k, rx_l, rx_u, 8'h00});
    rx_r <= $random(seed) % 3 != 0;
  end
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    {srst, arst} <= 2'h0;
    repeat (2) @(posedge clock_i);
    bus(0, 4'h0, 32'h0);
    chk_reg("ctrl reset", 32'h14, rdv);
    bus(0, 4'h8, 32'h0);
    chk_reg("unmapped", 32'h0, rdv);
    chk_reg("rx status", 32'h1E, 32'(stat));
    bus(1, 4'h0, 32'h15);
    repeat (2) @(posedge clock_i);
    chk_reg("flow control", 32'h1, 32'(fc));
    $display("test registers done");
    for (i = 0; i < 6; i++) begin
      pkt(0, 1 + i % 3, i[0], i[1]);
      while (exp_ll.size() != 0) @(posedge clock_i);
    end
    $display("test link transmit done");
    for (i = 0; i < 6; i++) pkt(1, 1 + i % 3, i % 3 == 2, i[0]);
    while (exp_tl.size() != 0) @(posedge clock_i);
    repeat (100) @(posedge clock_i);
    $display("test link receive done");
    bus(0, 4'h4, 32'h0);
    chk_reg("status", 32'h20, rdv);
    $display("test release done");
    // transmit depth 8, requests blocked until six are stored
    bus(1, 4'h0, 32'h11);
    ren <= 1'b0;
    repeat (4) @(posedge clock_i);
    for (i = 0; i < 6; i++) pkt(0, 2, 1'b0, i[0]);
    repeat (20) @(posedge clock_i);
    chk_reg("response only", 32'h1, 32'(ronly));
    chk_reg("requests held", 32'h0C, 32'(exp_ll.size()));
    ren <= 1'b1;
    while (exp_ll.size() != 0) @(posedge clock_i);
    repeat (100) @(posedge clock_i);
    chk_reg("response only off", 32'h0, 32'(ronly));
    $display("test request gate done");
    report_and_stop();
  end
endmodule
`default_nettype wire
